// [core/tdt_timer.sv]
// Purpose: configurable delay timer function with APB registers
// Assumes: trigger, clear and power inputs come from logic on clk
// Notes:   time is counted in steps of the selected base; the first
//          step after a start may be short by up to one step
//
// Notes on behaviour
// - on-delay: rising trigger restarts elapsed time
// - on-delay: output high when delay reached
// - on-delay: early trigger fall clears elapsed time
// - on-delay: output low while trigger low
// - three time bases with clamped maxima
// - delay may come from another block
// - off-delay: rising trigger sets output at once
// - off-delay: falling trigger restarts, expiry clears
// - off-delay: each new pulse restarts timing
// - off-delay: clear zeroes all, beats trigger
// - on/off: rise starts high delay, expiry sets output
// - on/off: early fall cancels high delay
// - on/off: fall starts low delay, expiry clears output
// - on/off: early rise cancels low delay
// - retentive: rise starts, output set on expiry
// - retentive: later pulses leave timing alone
// - retentive: clear, a control write or a restore without retention resets; clear beats trigger
// - power restore clears unless retentive is set
// - wiping: pulse sets output until expiry
// - wiping: trigger fall drops output at once
// - delay held as two fields per base
// - trigger and clear inputs individually invertible
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tdt_params.svh"

module tdt_timer #(
   parameter int unsigned CYC_10MS = `TDT_STEP_S_NS / `TDT_CLK_PERIOD_NS
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        trg_in,
   input  wire logic        clr_in,
   input  wire logic        pwr_lost,
   input  wire logic [15:0] src_value,
   output logic [7:0]       src_block,
   output logic             q_out
);
   import tdt_pkg::*;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   tdt_mode_e   mode_reg;
   tdt_base_e   base_reg;
   logic        inv_trg_reg;
   logic        inv_clr_reg;
   logic        retain_reg;
   logic        src_ext_reg;
   logic [6:0]  hi_up_reg;
   logic [6:0]  hi_lo_reg;
   logic [6:0]  lo_up_reg;
   logic [6:0]  lo_lo_reg;
   logic [7:0]  block_reg;
   logic [31:0] prdata_reg;

   // timer state
   logic        q_reg;
   logic        run_reg;
   logic        phase_low_reg;
   tdt_steps_t  elapsed_reg;
   logic        trg_prev_reg;
   logic        pwr_prev_reg;

   // combinational helpers
   logic        wr_en;
   logic        rd_setup;
   logic        addr_hit;
   logic        ctrl_clr;
   logic        trg_eff;
   logic        clr_eff;
   logic        trg_rise;
   logic        trg_fall;
   logic        restore;
   logic        hold_ok;
   logic        tick;
   logic        tick_10ms;
   logic        tick_1s;
   logic        tick_1min;
   logic        reached;
   tdt_steps_t  high_tgt;
   tdt_steps_t  low_tgt;
   tdt_steps_t  ext_tgt;
   tdt_steps_t  target;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   // two-field delay decode
   function automatic tdt_steps_t tdt_steps(input tdt_base_e b,
                                            input logic [6:0] up,
                                            input logic [6:0] lo);
      logic [6:0] up_c;
      logic [6:0] lo_c;
      up_c = (up > `TDT_UP_MAX) ? `TDT_UP_MAX : up;
      lo_c = lo;
      case (b)
         TDT_BASE_M, TDT_BASE_H: begin
            if (lo > `TDT_LO_MAX_MH) lo_c = `TDT_LO_MAX_MH;
            tdt_steps = 14'(up_c) * `TDT_MUL_MH + 14'(lo_c);
         end
         default: begin
            if (lo > `TDT_LO_MAX_S) lo_c = `TDT_LO_MAX_S;
            tdt_steps = 14'(up_c) * `TDT_MUL_S + 14'(lo_c);
         end
      endcase
   endfunction : tdt_steps

   // address decode, shared by write enable and error answer
   function automatic logic tdt_mapped(input logic [7:0] a);
      case (a)
         `TDT_OFS_CTRL, `TDT_OFS_HIGH_DELAY, `TDT_OFS_LOW_DELAY,
         `TDT_OFS_SRC, `TDT_OFS_STATUS, `TDT_OFS_ELAPSED: tdt_mapped = 1'b1;
         default: tdt_mapped = 1'b0;
      endcase
   endfunction : tdt_mapped

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // zero wait states: read data is captured in the setup cycle
   assign addr_hit = tdt_mapped(paddr);
   assign wr_en    = psel && penable && pwrite && addr_hit;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_hit;
   assign prdata   = prdata_reg;
   assign ctrl_clr = wr_en && (paddr == `TDT_OFS_CTRL);

   // control register; a write restarts the timer from idle
   always_ff @(posedge clk) begin
      if (srst) begin
         {src_ext_reg, retain_reg, inv_clr_reg, inv_trg_reg} <= 4'h0;
         mode_reg <= TDT_MODE_ON;
         base_reg <= TDT_BASE_S;
      end else if (ctrl_clr) begin
         mode_reg    <= tdt_mode_e'(pwdata[`TDT_F_MODE]);
         base_reg    <= tdt_base_e'(pwdata[`TDT_F_BASE]);
         inv_trg_reg <= pwdata[`TDT_B_INV_TRG];
         inv_clr_reg <= pwdata[`TDT_B_INV_CLR];
         retain_reg  <= pwdata[`TDT_B_RETAIN];
         src_ext_reg <= pwdata[`TDT_B_SRC_EXT];
      end
   end

   // delay and source registers; stored raw, clamped on use
   always_ff @(posedge clk) begin
      if (srst) begin
         hi_up_reg <= `TDT_DLY_RST;
         hi_lo_reg <= `TDT_DLY_RST;
         lo_up_reg <= `TDT_DLY_RST;
         lo_lo_reg <= `TDT_DLY_RST;
         block_reg <= `TDT_BLOCK_RST;
      end else if (wr_en) begin
         case (paddr)
            `TDT_OFS_HIGH_DELAY: begin
               hi_up_reg <= pwdata[`TDT_F_DLY_UP];
               hi_lo_reg <= pwdata[`TDT_F_DLY_LO];
            end
            `TDT_OFS_LOW_DELAY: begin
               lo_up_reg <= pwdata[`TDT_F_DLY_UP];
               lo_lo_reg <= pwdata[`TDT_F_DLY_LO];
            end
            `TDT_OFS_SRC: block_reg <= pwdata[`TDT_F_BLOCK];
            default: ;
         endcase
      end
   end

   // read mux; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_reg <= 32'h00000000;
         case (paddr)
            `TDT_OFS_CTRL: begin
               prdata_reg[`TDT_F_MODE]    <= mode_reg;
               prdata_reg[`TDT_F_BASE]    <= base_reg;
               prdata_reg[`TDT_B_INV_TRG] <= inv_trg_reg;
               prdata_reg[`TDT_B_INV_CLR] <= inv_clr_reg;
               prdata_reg[`TDT_B_RETAIN]  <= retain_reg;
               prdata_reg[`TDT_B_SRC_EXT] <= src_ext_reg;
            end
            `TDT_OFS_HIGH_DELAY: begin
               prdata_reg[`TDT_F_DLY_UP] <= hi_up_reg;
               prdata_reg[`TDT_F_DLY_LO] <= hi_lo_reg;
            end
            `TDT_OFS_LOW_DELAY: begin
               prdata_reg[`TDT_F_DLY_UP] <= lo_up_reg;
               prdata_reg[`TDT_F_DLY_LO] <= lo_lo_reg;
            end
            `TDT_OFS_SRC:     prdata_reg[`TDT_F_BLOCK] <= block_reg;
            `TDT_OFS_STATUS:  prdata_reg[`TDT_F_STATUS] <= {phase_low_reg, run_reg, q_reg};
            `TDT_OFS_ELAPSED: prdata_reg[`TDT_F_ELAPSED] <= elapsed_reg;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // inputs, edges and time base
   // ----------------------------------------------------------------
   // per-input inversion
   assign trg_eff = trg_in ^ inv_trg_reg;
   assign clr_eff = clr_in ^ inv_clr_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         trg_prev_reg <= 1'b0;
         pwr_prev_reg <= 1'b0;
      end else begin
         trg_prev_reg <= trg_eff;
         pwr_prev_reg <= pwr_lost;
      end
   end
   assign trg_rise = trg_eff && !trg_prev_reg;
   assign trg_fall = !trg_eff && trg_prev_reg;
   assign restore  = pwr_prev_reg && !pwr_lost;
   assign hold_ok  = !pwr_lost && !restore && !ctrl_clr;

   tdt_tick_gen #(
      .CYC_10MS (CYC_10MS)
   ) u_ticks (
      .clk       (clk),
      .srst      (srst),
      .tick_10ms (tick_10ms),
      .tick_1s   (tick_1s),
      .tick_1min (tick_1min)
   );

   always_comb begin
      case (base_reg)
         TDT_BASE_M: tick = tick_1s;
         TDT_BASE_H: tick = tick_1min;
         default:    tick = tick_10ms;
      endcase
   end

   assign src_block = block_reg;
   assign ext_tgt   = (src_value[`TDT_F_OVF] != 2'b00) ? `TDT_SAT : src_value[`TDT_F_SRC_VAL];
   assign high_tgt  = src_ext_reg ?
                      ((base_reg == TDT_BASE_S) ?
                       ((ext_tgt > `TDT_EXT_MAX_S) ? `TDT_EXT_MAX_S : ext_tgt) :
                       ((ext_tgt > `TDT_EXT_MAX_MH) ? `TDT_EXT_MAX_MH : ext_tgt)) :
                      tdt_steps(base_reg, hi_up_reg, hi_lo_reg);
   assign low_tgt   = tdt_steps(base_reg, lo_up_reg, lo_lo_reg);
   assign target    = (mode_reg == TDT_MODE_ONOFF && phase_low_reg) ? low_tgt : high_tgt;
   // >= so a delay lowered mid-run still ends the run
   assign reached   = run_reg && (elapsed_reg >= target);
   assign q_out     = q_reg;

   // ----------------------------------------------------------------
   // timer core
   // ----------------------------------------------------------------
   // later assignments in the case override the plain step count
   always_ff @(posedge clk) begin
      if (srst) begin
         q_reg         <= 1'b0;
         run_reg       <= 1'b0;
         phase_low_reg <= 1'b0;
         elapsed_reg   <= '0;
      end else if (restore) begin
         if (!retain_reg) begin
            q_reg         <= 1'b0;
            run_reg       <= 1'b0;
            phase_low_reg <= 1'b0;
            elapsed_reg   <= '0;
         end
      end else if (pwr_lost) begin
         q_reg <= q_reg;  // frozen while power is away
      end else if (ctrl_clr) begin
         q_reg         <= 1'b0;
         run_reg       <= 1'b0;
         phase_low_reg <= 1'b0;
         elapsed_reg   <= '0;
      end else begin
         if (run_reg && !reached && tick) begin
            elapsed_reg <= elapsed_reg + 14'h0001;
         end
         case (mode_reg)
            TDT_MODE_ON: begin
               if (!trg_eff) begin
                  q_reg       <= 1'b0;
                  run_reg     <= 1'b0;
                  elapsed_reg <= '0;
               end else if (trg_rise) begin
                  run_reg     <= 1'b1;
                  elapsed_reg <= '0;
               end else if (reached) begin
                  q_reg   <= 1'b1;
                  run_reg <= 1'b0;
               end
            end
            TDT_MODE_OFF: begin
               if (clr_eff) begin
                  q_reg       <= 1'b0;
                  run_reg     <= 1'b0;
                  elapsed_reg <= '0;
               end else if (trg_rise) begin
                  q_reg       <= 1'b1;
                  run_reg     <= 1'b0;
                  elapsed_reg <= '0;
               end else if (trg_fall && q_reg) begin
                  run_reg     <= 1'b1;
                  elapsed_reg <= '0;
               end else if (reached) begin
                  q_reg   <= 1'b0;
                  run_reg <= 1'b0;
               end
            end
            TDT_MODE_ONOFF: begin
               if (trg_rise || trg_fall) begin
                  elapsed_reg   <= '0;
                  run_reg       <= (trg_rise != q_reg);
                  phase_low_reg <= trg_fall;
               end else if (reached) begin
                  q_reg   <= !phase_low_reg;
                  run_reg <= 1'b0;
               end
            end
            TDT_MODE_RETON: begin
               if (clr_eff) begin
                  q_reg       <= 1'b0;
                  run_reg     <= 1'b0;
                  elapsed_reg <= '0;
               end else if (trg_rise && !run_reg && !q_reg) begin
                  run_reg     <= 1'b1;
                  elapsed_reg <= '0;
               end else if (reached) begin
                  q_reg   <= 1'b1;
                  run_reg <= 1'b0;
               end
            end
            TDT_MODE_WIPE: begin
               if (!trg_eff) begin
                  q_reg       <= 1'b0;
                  run_reg     <= 1'b0;
                  elapsed_reg <= '0;
               end else if (trg_rise) begin
                  q_reg       <= 1'b1;
                  run_reg     <= 1'b1;
                  elapsed_reg <= '0;
               end else if (reached) begin
                  q_reg   <= 1'b0;
                  run_reg <= 1'b0;
               end
            end
            default: begin
               q_reg   <= 1'b0;
               run_reg <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_ondly_start: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_ON && trg_rise && hold_ok) |=> (run_reg && elapsed_reg == 14'h0000))
      else $error("on-delay did not restart on rising trigger");

   a_ondly_fire: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_ON && reached && trg_eff && !trg_rise && hold_ok) |=> q_reg)
      else $error("on-delay output not set at expiry");

   a_ondly_low: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_ON && !trg_eff && hold_ok) |=> (!q_reg && !run_reg))
      else $error("on-delay output high with trigger low");

   a_offdly_rise: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_OFF && trg_rise && !clr_eff && hold_ok) |=> q_reg)
      else $error("off-delay output not set on rising trigger");

   a_offdly_fall: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_OFF && trg_fall && q_reg && !clr_eff && hold_ok)
      |=> (q_reg && run_reg && elapsed_reg == 14'h0000))
      else $error("off-delay did not restart on falling trigger");

   a_offdly_clear: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_OFF && clr_eff && hold_ok) |=> (!q_reg && elapsed_reg == 14'h0000))
      else $error("off-delay clear did not win");

   a_onoff_cancel: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_ONOFF && trg_fall && !q_reg && hold_ok) |=> (!run_reg && !q_reg))
      else $error("on/off high delay not cancelled");

   a_reton_ignore: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_RETON && run_reg && !reached && trg_rise && !clr_eff && hold_ok)
      |=> (run_reg && elapsed_reg >= $past(elapsed_reg)))
      else $error("retentive timing disturbed by trigger");

   a_wipe_fall: assert property (@(posedge clk) disable iff (srst)
      (mode_reg == TDT_MODE_WIPE && trg_fall && hold_ok) |=> !q_reg)
      else $error("wiping output not dropped on falling trigger");

   a_power_clear: assert property (@(posedge clk) disable iff (srst)
      (restore && !retain_reg) |=> (!q_reg && elapsed_reg == 14'h0000 && !run_reg))
      else $error("state kept after power restore without retention");

endmodule : tdt_timer

// [core/tdt_params.svh]
// Purpose: named constants of the delay timer block
// Assumes: 20 MHz system clock
// Notes:   offsets are byte addresses on the APB side
`ifndef TDT_PARAMS_SVH
`define TDT_PARAMS_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define TDT_CLK_PERIOD_NS   50
`define TDT_STEP_S_NS       10000000
`define TDT_CENTI_LAST      7'd99
`define TDT_SEC_LAST        6'd59

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TDT_OFS_CTRL        8'h00
`define TDT_OFS_HIGH_DELAY  8'h04
`define TDT_OFS_LOW_DELAY   8'h08
`define TDT_OFS_SRC         8'h0C
`define TDT_OFS_STATUS      8'h10
`define TDT_OFS_ELAPSED     8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TDT_F_MODE          2:0
`define TDT_F_BASE          4:3
`define TDT_B_INV_TRG       5
`define TDT_B_INV_CLR       6
`define TDT_B_RETAIN        7
`define TDT_B_SRC_EXT       8
`define TDT_F_DLY_LO        6:0
`define TDT_F_DLY_UP        14:8
`define TDT_F_BLOCK         7:0
`define TDT_F_ELAPSED       13:0
`define TDT_F_SRC_VAL       13:0
`define TDT_F_OVF           15:14
`define TDT_F_STATUS        2:0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define TDT_CTRL_RST        9'h000
`define TDT_DLY_RST         7'h00
`define TDT_BLOCK_RST       8'h00
`define TDT_UP_MAX          7'd99
`define TDT_LO_MAX_S        7'd99
`define TDT_LO_MAX_MH       7'd59
`define TDT_MUL_S           14'd100
`define TDT_MUL_MH          14'd60
`define TDT_EXT_MAX_S       14'd9999
`define TDT_EXT_MAX_MH      14'd5999
`define TDT_SAT             14'h3FFF

`endif

// [core/tdt_pkg.sv]
// Purpose: types shared by the delay timer block
// Assumes: nothing beyond the params header
// Notes:   unlisted base code 2'b11 behaves as seconds, but clamps an external delay to the minute/hour limit
package tdt_pkg;

   // ----------------------------------------------------------------
   // timer function modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TDT_MODE_ON    = 3'b000,
      TDT_MODE_OFF   = 3'b001,
      TDT_MODE_ONOFF = 3'b010,
      TDT_MODE_RETON = 3'b011,
      TDT_MODE_WIPE  = 3'b100
   } tdt_mode_e;

   // ----------------------------------------------------------------
   // time bases
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TDT_BASE_S = 2'b00,
      TDT_BASE_M = 2'b01,
      TDT_BASE_H = 2'b10
   } tdt_base_e;

   typedef logic [13:0] tdt_steps_t;

endpackage : tdt_pkg

// [core/tdt_tick_gen.sv]
// Purpose: free running prescaler giving 10 ms, 1 s and 1 min ticks
// Assumes: clk at 20 MHz, srst synchronous active high
// Notes:   ticks are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`include "tdt_params.svh"

module tdt_tick_gen #(
   parameter int unsigned CYC_10MS = `TDT_STEP_S_NS / `TDT_CLK_PERIOD_NS
) (
   input  wire logic clk,
   input  wire logic srst,
   output logic      tick_10ms,
   output logic      tick_1s,
   output logic      tick_1min
);

   logic [17:0] cyc_reg;
   logic [6:0]  centi_reg;
   logic [5:0]  sec_reg;
   logic        cyc_wrap;

   assign cyc_wrap = (cyc_reg == 18'(CYC_10MS - 1));

   // ----------------------------------------------------------------
   // cascaded counters
   // ----------------------------------------------------------------
   // cycle divider down to the 10 ms step
   always_ff @(posedge clk) begin
      if (srst) begin
         cyc_reg <= '0;
      end else if (cyc_wrap) begin
         cyc_reg <= '0;
      end else begin
         cyc_reg <= cyc_reg + 18'h00001;
      end
   end

   // hundredths then seconds; ticks registered so they align with counters
   always_ff @(posedge clk) begin
      if (srst) begin
         centi_reg <= '0;
         sec_reg   <= '0;
         tick_10ms <= 1'b0;
         tick_1s   <= 1'b0;
         tick_1min <= 1'b0;
      end else begin
         tick_10ms <= cyc_wrap;
         tick_1s   <= cyc_wrap && (centi_reg == `TDT_CENTI_LAST);
         tick_1min <= cyc_wrap && (centi_reg == `TDT_CENTI_LAST) &&
                      (sec_reg == `TDT_SEC_LAST);
         if (cyc_wrap) begin
            if (centi_reg == `TDT_CENTI_LAST) begin
               centi_reg <= '0;
               sec_reg   <= (sec_reg == `TDT_SEC_LAST) ? 6'h00 : sec_reg + 6'h01;
            end else begin
               centi_reg <= centi_reg + 7'h01;
            end
         end
      end
   end

endmodule : tdt_tick_gen

// [testbench/tdt_src_model.sv]
// Purpose: stand-in for the function block whose value feeds the delay
// Assumes: value is in steps of the selected time base
// Notes:   value follows the chosen block number, so a random pick moves it
`timescale 1ns/1ps

module tdt_src_model (
   input  wire logic [7:0]  src_block,
   output logic      [15:0] src_value
);
   assign src_value = {8'h00, src_block};
endmodule : tdt_src_model

// [testbench/delay_timer_functions_test.sv]
// Purpose: self-checking bench of the delay timer through APB status reads
// Assumes: 20 ticks of clk per 10 ms step
// Notes:   first step may be short, so checks sit well inside each window
`timescale 1ns/1ps
`include "tdt_params.svh"

module delay_timer_functions_test;
   import tdt_pkg::*;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        trg_in = 1'b0, clr_in = 1'b0, pwr_lost = 1'b0, pready, pslverr, q_out;
   logic [7:0]  paddr = 8'h00, src_block, sel;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] src_value;
   logic [32:0] exp_q[$], mask_q[$], note_e, note_m;
   int          miscompares = 0, checked = 0;

   always #25 clk = ~clk;

   tdt_timer #(.CYC_10MS(20)) uut (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trg_in(trg_in),
      .clr_in(clr_in), .pwr_lost(pwr_lost), .src_value(src_value),
      .src_block(src_block), .q_out(q_out));
   tdt_src_model far_end (.src_block(src_block), .src_value(src_value));

   // ----------------------------------------------------------------
   // bus tasks and comparison
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // request held until pready is seen high; only the watchdog ends a hung wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      mask_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // bit 0 of status and the error flag only
   task automatic chk_q(input int w, input logic e);
      repeat (w) @(posedge clk);
      rd(`TDT_OFS_STATUS, {32'h0, e}, 33'h1_0000_0001);
   endtask : chk_q

   task automatic cmp_rd(input logic [32:0] s, input logic [32:0] e, input logic [32:0] m);
      checked++;
      if ((s & m) !== (e & m)) begin
         miscompares++;
         $display("MISMATCH read expected %h seen %h", e & m, s & m);
      end
   endtask : cmp_rd

   task automatic cmp_q(input logic s, input logic e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH q_out expected %b seen %b", e, s);
      end
   endtask : cmp_q

   // monitor takes the oldest note at each completed read
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         note_e = exp_q.pop_front();
         note_m = mask_q.pop_front();
         cmp_rd({pslverr, prdata}, note_e, note_m);
         // the output pin must agree with the expected status bit at each status read
         if (paddr == `TDT_OFS_STATUS) cmp_q(q_out, note_e[0]);
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      sel = 8'($urandom(38674));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(`TDT_OFS_CTRL, 33'h0, '1);
      rd(8'h40, 33'h1_0000_0000, '1);
      sel = 8'(2 + $urandom % 3);
      apb(1'b1, `TDT_OFS_SRC, {24'h0, sel});
      rd(`TDT_OFS_SRC, {25'h0, sel}, '1);
      apb(1'b1, `TDT_OFS_HIGH_DELAY, 32'h3);
      apb(1'b1, `TDT_OFS_LOW_DELAY, 32'h3);
      apb(1'b1, `TDT_OFS_CTRL, 32'h0);
      trg_in <= 1'b1;
      chk_q(30, 1'b0);
      chk_q(45, 1'b1);
      trg_in <= 1'b0;
      chk_q(2, 1'b0);
      trg_in <= 1'b1;
      repeat (30) @(posedge clk);
      trg_in <= 1'b0;
      chk_q(45, 1'b0);
      // inverted trigger: input falling acts as a rise
      trg_in <= 1'b1;
      apb(1'b1, `TDT_OFS_CTRL, 32'h20);
      trg_in <= 1'b0;
      chk_q(75, 1'b1);
      apb(1'b1, `TDT_OFS_CTRL, 32'h1);
      trg_in <= 1'b1;
      chk_q(2, 1'b1);
      trg_in <= 1'b0;
      chk_q(30, 1'b1);
      trg_in <= 1'b1;
      chk_q(0, 1'b1);
      trg_in <= 1'b0;
      chk_q(30, 1'b1);
      chk_q(45, 1'b0);
      trg_in <= 1'b1;
      clr_in <= 1'b1;
      chk_q(2, 1'b0);
      // on/off needs a fresh rise after the mode change
      clr_in <= 1'b0;
      trg_in <= 1'b0;
      apb(1'b1, `TDT_OFS_CTRL, 32'h2);
      trg_in <= 1'b1;
      chk_q(75, 1'b1);
      trg_in <= 1'b0;
      chk_q(30, 1'b1);
      chk_q(45, 1'b0);
      apb(1'b1, `TDT_OFS_CTRL, 32'h3);
      trg_in <= 1'b1;
      @(posedge clk);
      trg_in <= 1'b0;
      chk_q(30, 1'b0);
      trg_in <= 1'b1;
      @(posedge clk);
      trg_in <= 1'b0;
      chk_q(45, 1'b1);
      pwr_lost <= 1'b1;
      repeat (3) @(posedge clk);
      pwr_lost <= 1'b0;
      chk_q(2, 1'b0);
      trg_in <= 1'b1;
      clr_in <= 1'b1;
      chk_q(75, 1'b0);
      clr_in <= 1'b0;
      trg_in <= 1'b0;
      // retention on: timing freezes while power is away and then resumes
      apb(1'b1, `TDT_OFS_CTRL, 32'h83);
      trg_in <= 1'b1;
      chk_q(20, 1'b0);
      pwr_lost <= 1'b1;
      chk_q(100, 1'b0);
      pwr_lost <= 1'b0;
      chk_q(75, 1'b1);
      trg_in <= 1'b0;
      apb(1'b1, `TDT_OFS_CTRL, 32'h4);
      trg_in <= 1'b1;
      chk_q(2, 1'b1);
      chk_q(75, 1'b0);
      trg_in <= 1'b0;
      @(posedge clk);
      trg_in <= 1'b1;
      chk_q(2, 1'b1);
      trg_in <= 1'b0;
      chk_q(2, 1'b0);
      // delay taken from the far block, in steps of the random pick
      apb(1'b1, `TDT_OFS_CTRL, 32'h100);
      trg_in <= 1'b1;
      chk_q((sel - 1) * 20 - 8, 1'b0);
      chk_q(30, 1'b1);
      // minute base: two steps of one second each
      trg_in <= 1'b0;
      apb(1'b1, `TDT_OFS_HIGH_DELAY, 32'h2);
      apb(1'b1, `TDT_OFS_CTRL, 32'h08);
      trg_in <= 1'b1;
      chk_q(1990, 1'b0);
      chk_q(2100, 1'b1);
      complete_run();
   end

   // watchdog well beyond the few thousand cycles of the sequence
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end
endmodule : delay_timer_functions_test
